/* File: testbench/oct_remote_model.sv */
`timescale 1ns/1ps
module oct_remote_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        frame_strobe,
    input  wire logic [95:0] serial_out_pair,
    input  wire logic [7:0]  arm,
    output int               bits_checked,
    output int               bit_errors,
    output int               frame_errors
);
    // ****
    // Self-synchronising pattern checker
    // ****
    // Both bit orders are tried, since the word order on the wire is not fixed
    logic [14:0] hist [8];
    int          fill [8];
    int          err_a;
    int          err_b;

    always @(posedge pclk or negedge presetn) begin : chk
        logic [11:0] f;
        logic        b;
        if (!presetn) begin
            bits_checked = 0;
            err_a = 0;
            err_b = 0;
            frame_errors = 0;
            for (int c = 0; c < 8; c++) fill[c] = 0;
        end else if (frame_strobe) begin
            for (int c = 0; c < 8; c++) begin
                f = serial_out_pair[c*12 +: 12];
                if (f[0] !== 1'b1 || f[11] !== 1'b0) frame_errors++;
                if (!arm[c]) fill[c] = 0;
                for (int k = 1; k <= 10 && arm[c]; k++) begin
                    b = f[k];
                    if (fill[c] >= 15) begin
                        bits_checked++;
                        err_a += int'(b ^ hist[c][13] ^ hist[c][14]);
                        err_b += int'(b ^ hist[c][0] ^ hist[c][14]);
                    end
                    hist[c] = {hist[c][13:0], b};
                    fill[c]++;
                end
            end
        end
    end

    assign bit_errors = (err_a < err_b) ? err_a : err_b;
endmodule : oct_remote_model

/* File: testbench/test_octal_serializer_prbs_test_select.sv */
`timescale 1ns/1ps
module test_octal_serializer_prbs_test_select;
    // ****
    // Signals
    // ****
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        transmit_clock = 1'b0;
    logic        test_activate = 1'b0;
    logic [3:0]  test_channel_select = 4'hF;
    logic        driver_output_enable = 1'b1;
    logic        master_sleep_n = 1'b1;
    logic [7:0]  channel_sleep_n = 8'hFF;
    logic [7:0]  lock_pattern_request = 8'h00;
    logic [79:0] parallel_word_in = 80'h0;
    logic [95:0] serial_out_pair;
    logic [7:0]  serial_out_en;
    logic        frame_strobe;
    logic [7:0]  arm = 8'h00;
    logic [95:0] got;
    logic [31:0] rd;
    logic [31:0] d;
    logic        err;
    logic        seen;
    int          lk [8];
    int          bits_checked;
    int          bit_errors;
    int          frame_errors;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          ticks = 0;
    int          cyc = 0;

    oct_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .transmit_clock(transmit_clock), .test_activate(test_activate),
        .test_channel_select(test_channel_select), .master_sleep_n(master_sleep_n),
        .driver_output_enable(driver_output_enable), .channel_sleep_n(channel_sleep_n),
        .lock_pattern_request(lock_pattern_request), .parallel_word_in(parallel_word_in),
        .serial_out_pair(serial_out_pair), .serial_out_en(serial_out_en),
        .frame_strobe(frame_strobe));

    oct_remote_model i_rem (.pclk(pclk), .presetn(presetn), .frame_strobe(frame_strobe),
        .serial_out_pair(serial_out_pair), .arm(arm), .bits_checked(bits_checked),
        .bit_errors(bit_errors), .frame_errors(frame_errors));

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    // ****
    // Helpers
    // ****
    function automatic logic [7:0] exp_mask(input logic a, input logic [3:0] s);
        if (!a || s > 4'h8) return 8'h00;
        if (s == 4'h8) return 8'hFF;
        return 8'h01 << s;
    endfunction : exp_mask

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t value %h expected %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_frame(input logic [11:0] g, input logic [11:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t frame %h expected %h", $time, g, e);
        end
    endtask : chk_frame

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One transmit clock period of 200 ns; pins settle well before its rise
    task automatic tick();
        logic [11:0] e;
        repeat (4) @(posedge pclk);
        transmit_clock <= 1'b1;
        seen = 1'b0;
        for (int n = 0; n < 4; n++) begin
            @(posedge pclk);
            if (n == 3) transmit_clock <= 1'b0;
            if (frame_strobe === 1'b1) begin
                got = serial_out_pair;
                seen = 1'b1;
            end
        end
        ticks++;
        chk_word({31'h0, seen}, 32'h1);
        for (int c = 0; c < 8; c++) begin
            e = (lk[c] >= 4) ? 12'h03F : {1'b0, parallel_word_in[c*10 +: 10], 1'b1};
            if (!arm[c]) chk_frame(got[c*12 +: 12], e);
            lk[c] = lock_pattern_request[c] ? ((lk[c] < 4) ? lk[c] + 1 : 4) : 0;
        end
        chk_word({24'h0, serial_out_en}, {24'h0, (driver_output_enable && master_sleep_n)
            ? channel_sleep_n : 8'h00});
    endtask : tick

    task automatic set_pins(input logic a, input logic [3:0] s, input logic rnd);
        test_activate <= a;
        test_channel_select <= s;
        arm <= exp_mask(a, s);
        for (int c = 0; c < 8; c++) begin
            parallel_word_in[c*10 +: 10] <= c[0] ? 10'($urandom)
                : {1'b0, 8'($urandom), 1'b1};
            if ($urandom_range(7) == 0) lock_pattern_request[c] <= ~lock_pattern_request[c];
        end
        if (rnd) begin
            driver_output_enable <= ($urandom_range(5) != 0);
            master_sleep_n <= ($urandom_range(9) != 0);
            channel_sleep_n <= 8'($urandom);
        end
    endtask : set_pins

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // Room for about 1000 link cycles; the test runs 130 plus register traffic
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            summarize();
        end
    end

    // ****
    // Tests
    // ****
    initial begin
        void'($urandom(32'h1E40D291));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk_word(rd, 32'h0000_7FFF);
        d = $urandom | 32'h1;
        apb(1'b1, 12'h000, d);
        apb(1'b0, 12'h000, 32'h0);
        chk_word(rd, {17'h0, d[14:0]});
        apb(1'b0, 12'h00C, 32'h0);
        chk_word(rd, 32'h0);
        chk_word({31'h0, err}, 32'h1);
        $display("registers done");
        for (int s = 0; s < 16; s++) begin
            set_pins(1'b1, 4'(s), 1'b0);
            repeat (3) tick();
            apb(1'b0, 12'h004, 32'h0);
            chk_word(rd & 32'h00FF_FF00, {8'h0, channel_sleep_n, exp_mask(1'b1, 4'(s)), 8'h0});
        end
        set_pins(1'b0, 4'h8, 1'b0);
        repeat (2) tick();
        $display("select codes done");
        for (int i = 0; i < 80; i++) begin
            set_pins($urandom_range(3) != 0, 4'($urandom), 1'b1);
            tick();
        end
        $display("random traffic done");
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        apb(1'b0, 12'h008, 32'h0);
        chk_word(rd, 32'(ticks));
        chk_word(32'(bit_errors), 32'h0);
        chk_word(32'(frame_errors), 32'h0);
        chk_word({31'h0, bits_checked > 0}, 32'h1);
        $display("link checker done");
        summarize();
    end
endmodule : test_octal_serializer_prbs_test_select

/* File: verilog/oct_apb.sv */
`timescale 1ns/1ps
module oct_apb (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [oct_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    oct_reg_if.regs                        regs
);
    logic setup;
    logic hit;

    assign setup = psel && !penable;
    assign hit   = (paddr == oct_pkg::OFF_SEED) || (paddr == oct_pkg::OFF_STATUS)
                   || (paddr == oct_pkg::OFF_FRAMES);

    // One wait-free access phase: answer prepared during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit;
            prdata  <= '0;
            if (setup && !pwrite) begin
                case (paddr)
                    oct_pkg::OFF_SEED:   prdata <= {{(32-oct_pkg::PRBS_W){1'b0}}, regs.seed};
                    oct_pkg::OFF_STATUS: prdata <= regs.status;
                    oct_pkg::OFF_FRAMES: prdata <= regs.frames;
                    default:             prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regs.seed <= oct_pkg::SEED_RST;
        end else if (psel && penable && pready && pwrite && paddr == oct_pkg::OFF_SEED) begin
            regs.seed <= pwdata[oct_pkg::PRBS_W-1:0];
        end
    end
endmodule : oct_apb

/* File: verilog/oct_pkg.sv */
package oct_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int            CHANNELS        = 8;
    localparam int            WORD_W          = 10;
    localparam int            FRAME_W         = 12;
    localparam int            SEL_W           = 4;
    localparam int            DATA_LSB        = 1;
    localparam int            START_POS       = 0;
    localparam int            STOP_POS        = 11;
    localparam int            SERIAL_MBPS_MAX = 660;

    // ************************************************************
    // Framing and test codes
    // ************************************************************
    localparam logic              START_BIT   = 1'b1;
    localparam logic              STOP_BIT    = 1'b0;
    localparam logic [FRAME_W-1:0] LOCK_FRAME = 12'h03F;
    localparam logic [2:0]        LOCK_CYCLES = 3'h4;
    localparam logic [SEL_W-1:0]  SEL_ALL     = 4'h8;
    localparam logic [CHANNELS-1:0] MASK_NONE = 8'h00;
    localparam logic [CHANNELS-1:0] MASK_ALL  = 8'hFF;

    // ************************************************************
    // Pattern generator
    // ************************************************************
    localparam int              PRBS_W    = 15;
    localparam logic [PRBS_W-1:0] PRBS_TAPS = 15'h6000;
    localparam logic [PRBS_W-1:0] SEED_RST  = 15'h7FFF;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W     = 12;
    localparam logic [11:0] OFF_SEED   = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_FRAMES = 12'h008;

    function automatic logic [CHANNELS-1:0] test_mask(input logic act,
                                                      input logic [SEL_W-1:0] sel);
        logic [CHANNELS-1:0] m;
        m = MASK_NONE;
        if (act && sel < SEL_ALL) begin
            m[sel[2:0]] = 1'b1;
        end else if (act && sel == SEL_ALL) begin
            m = MASK_ALL;
        end
        return m;
    endfunction : test_mask

    function automatic logic [FRAME_W-1:0] frame_of(input logic [WORD_W-1:0] w);
        return {STOP_BIT, w, START_BIT};
    endfunction : frame_of

endpackage : oct_pkg

/* File: verilog/oct_prbs.sv */
`timescale 1ns/1ps
module oct_prbs #(
    parameter int                 W     = oct_pkg::PRBS_W,
    parameter logic [W-1:0]       TAPS  = oct_pkg::PRBS_TAPS,
    parameter int                 OUT_W = oct_pkg::WORD_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             advance,
    input  wire logic             load,
    input  wire logic [W-1:0]     seed,
    output logic      [OUT_W-1:0] word
);
    logic [W-1:0] state;

    // An all-zero seed locks the register; software must avoid it
    function automatic logic [W+OUT_W-1:0] run(input logic [W-1:0] s);
        logic [W-1:0]     st;
        logic [OUT_W-1:0] w;
        logic             fb;
        st = s;
        w  = '0;
        fb = 1'b0;
        for (int i = 0; i < OUT_W; i++) begin
            fb   = ^(st & TAPS);
            st   = {st[W-2:0], fb};
            w[i] = fb;
        end
        return {st, w};
    endfunction : run

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= oct_pkg::SEED_RST;
            word  <= '0;
        end else if (load) begin
            // Primed with the first word, so a test opens on the sequence itself
            {state, word} <= run(seed);
        end else if (advance) begin
            {state, word} <= run(state);
        end
    end
endmodule : oct_prbs

/* File: verilog/oct_reg_if.sv */
`timescale 1ns/1ps
interface oct_reg_if;
    logic [oct_pkg::PRBS_W-1:0] seed;
    logic [31:0]                status;
    logic [31:0]                frames;
    modport regs (output seed, input status, input frames);
    modport core (input seed, output status, output frames);
endinterface : oct_reg_if

/* File: verilog/oct_top.sv */
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module oct_top (
    input  wire logic                                        pclk,
    input  wire logic                                        presetn,
    input  wire logic                                        psel,
    input  wire logic                                        penable,
    input  wire logic                                        pwrite,
    input  wire logic [oct_pkg::ADDR_W-1:0]                  paddr,
    input  wire logic [31:0]                                 pwdata,
    output logic      [31:0]                                 prdata,
    output logic                                             pready,
    output logic                                             pslverr,
    input  wire logic                                        transmit_clock,
    input  wire logic                                        test_activate,
    input  wire logic [oct_pkg::SEL_W-1:0]                   test_channel_select,
    input  wire logic                                        driver_output_enable,
    input  wire logic                                        master_sleep_n,
    input  wire logic [oct_pkg::CHANNELS-1:0]                channel_sleep_n,
    input  wire logic [oct_pkg::CHANNELS-1:0]                lock_pattern_request,
    input  wire logic [oct_pkg::CHANNELS*oct_pkg::WORD_W-1:0] parallel_word_in,
    output logic      [oct_pkg::CHANNELS*oct_pkg::FRAME_W-1:0] serial_out_pair,
    output logic      [oct_pkg::CHANNELS-1:0]                serial_out_en,
    output logic                                             frame_strobe
);
    localparam int CH  = oct_pkg::CHANNELS;
    localparam int WW  = oct_pkg::WORD_W;
    localparam int FW  = oct_pkg::FRAME_W;
    localparam int SW  = oct_pkg::SEL_W;
    localparam int IN_W = 4 + SW + 2 * CH + CH * WW;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Words ride the same two stages as the clock, so they stay aligned
    // with its edge; the source must hold them around that edge.
    logic [IN_W-1:0] sync_1;
    logic [IN_W-1:0] sync_2;
    logic            transmit_clock_d;
    logic            transmit_clock_s;
    logic            transmit_clock_rise;
    logic            act_s;
    logic [SW-1:0]   sel_s;
    logic            den_s;
    logic            ms_s;
    logic [CH-1:0]   chan_s;
    logic [CH-1:0]   req_s;
    logic [WW-1:0]   word_s [CH];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_1 <= '0;
            sync_2 <= '0;
        end else begin
            sync_1 <= {transmit_clock, test_activate, test_channel_select,
                       driver_output_enable, master_sleep_n, channel_sleep_n,
                       lock_pattern_request, parallel_word_in};
            sync_2 <= sync_1;
        end
    end

    assign {transmit_clock_s, act_s, sel_s, den_s, ms_s, chan_s, req_s} = sync_2[IN_W-1:CH*WW];

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_unpack
            assign word_s[g] = sync_2[g*WW +: WW];
        end
    endgenerate

    // ************************************************************
    // Shared transmit clock edge
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_clock_d <= 1'b0;
        end else begin
            transmit_clock_d <= transmit_clock_s;
        end
    end

    assign transmit_clock_rise = transmit_clock_s && !transmit_clock_d;

    // ************************************************************
    // Test select decode
    // ************************************************************
    logic [CH-1:0] test_mask_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_mask_q <= oct_pkg::MASK_NONE;
        end else begin
            test_mask_q <= oct_pkg::test_mask(act_s, sel_s);
        end
    end

    // ************************************************************
    // Pattern generator
    // ************************************************************
    oct_reg_if        regs ();
    logic [WW-1:0]    prbs_word;
    logic             any_test;

    assign any_test = |test_mask_q;

    oct_prbs #(
        .W     (oct_pkg::PRBS_W),
        .TAPS  (oct_pkg::PRBS_TAPS),
        .OUT_W (WW)
    ) u_prbs (
        .clk     (pclk),
        .rst_n   (presetn),
        .advance (transmit_clock_rise && any_test),
        .load    (!any_test),
        .seed    (regs.seed),
        .word    (prbs_word)
    );

    // ************************************************************
    // Lock request qualification
    // ************************************************************
    logic [2:0]    lock_cnt [CH];
    logic [CH-1:0] locking;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < CH; c++) begin
                lock_cnt[c] <= 3'h0;
            end
        end else if (transmit_clock_rise) begin
            for (int c = 0; c < CH; c++) begin
                if (!req_s[c]) begin
                    lock_cnt[c] <= 3'h0;
                end else if (lock_cnt[c] != oct_pkg::LOCK_CYCLES) begin
                    lock_cnt[c] <= lock_cnt[c] + 3'h1;
                end
            end
        end
    end

    generate
        for (g = 0; g < CH; g++) begin : g_lock
            assign locking[g] = (lock_cnt[g] == oct_pkg::LOCK_CYCLES);
        end
    endgenerate

    // ************************************************************
    // Frame builder
    // ************************************************************
    // Frames leave as 12-bit words, start bit first, to the bit-rate
    // shifter; the system clock cannot reach 12 bits per transmit cycle.
    logic [31:0] frames;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pair <= '0;
        end else if (transmit_clock_rise) begin
            for (int c = 0; c < CH; c++) begin
                if (test_mask_q[c]) begin
                    serial_out_pair[c*FW +: FW] <= oct_pkg::frame_of(prbs_word);
                end else if (locking[c]) begin
                    serial_out_pair[c*FW +: FW] <= oct_pkg::LOCK_FRAME;
                end else begin
                    serial_out_pair[c*FW +: FW] <= oct_pkg::frame_of(word_s[c]);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_strobe <= 1'b0;
        end else begin
            frame_strobe <= transmit_clock_rise;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames <= '0;
        end else if (transmit_clock_rise) begin
            frames <= frames + 32'h1;
        end
    end

    // ************************************************************
    // Output enables
    // ************************************************************
    // Only the enable is gated; framing state runs on, so a re-enable
    // picks up where it left off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_en <= '0;
        end else if (den_s && ms_s) begin
            serial_out_en <= chan_s;
        end else begin
            serial_out_en <= '0;
        end
    end

    // ************************************************************
    // Register slave
    // ************************************************************
    assign regs.status = {8'h00, serial_out_en, test_mask_q, locking};
    assign regs.frames = frames;

    oct_apb u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .regs    (regs)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_edge_then_strobe;
        transmit_clock_rise ##1 frame_strobe;
    endsequence

    a_test_idle_off: assert property (!act_s |=> test_mask_q == oct_pkg::MASK_NONE)
        else $error("test active with activate low");

    a_test_all_on: assert property ((act_s && sel_s == oct_pkg::SEL_ALL)
        |=> test_mask_q == oct_pkg::MASK_ALL)
        else $error("all-channel code did not select every channel");

    a_test_reserved: assert property ((act_s && sel_s > oct_pkg::SEL_ALL)
        |=> test_mask_q == oct_pkg::MASK_NONE)
        else $error("reserved code started a test");

    a_test_single: assert property ((act_s && sel_s < oct_pkg::SEL_ALL)
        |=> ($onehot(test_mask_q) && test_mask_q[$past(sel_s[2:0])]))
        else $error("single channel code selected wrong channels");

    a_capture_edge: assert property (transmit_clock_rise |-> s_edge_then_strobe)
        else $error("frame strobe missing after clock edge");

    a_oe_off: assert property (!den_s |=> serial_out_en == '0)
        else $error("outputs enabled while driver enable low");

    a_oe_resume: assert property ((den_s && ms_s) |=> serial_out_en == $past(chan_s))
        else $error("enables did not follow channel sleep on resume");

    generate
        for (g = 0; g < CH; g++) begin : g_chk
            a_frame_bounds: assert property (frame_strobe |->
                (serial_out_pair[g*FW+oct_pkg::START_POS] == oct_pkg::START_BIT &&
                 serial_out_pair[g*FW+oct_pkg::STOP_POS] == oct_pkg::STOP_BIT))
                else $error("frame clock bits wrong");

            a_prbs_frame: assert property ((transmit_clock_rise && test_mask_q[g])
                |=> serial_out_pair[g*FW+oct_pkg::DATA_LSB +: WW] == $past(prbs_word))
                else $error("selected channel not sending pattern");

            a_lock_frame: assert property ((transmit_clock_rise && !test_mask_q[g] && locking[g])
                |=> serial_out_pair[g*FW +: FW] == oct_pkg::LOCK_FRAME)
                else $error("lock pattern not sent");

            a_data_frame: assert property ((transmit_clock_rise && !test_mask_q[g] && !locking[g])
                |=> serial_out_pair[g*FW+oct_pkg::DATA_LSB +: WW] == $past(word_s[g]))
                else $error("data word not framed");

            a_lock_entry: assert property ((transmit_clock_rise && req_s[g] &&
                lock_cnt[g] == oct_pkg::LOCK_CYCLES - 3'h1) |=> locking[g])
                else $error("lock mode not entered after four edges");

            a_lock_exit: assert property ((transmit_clock_rise && !req_s[g]) |=> !locking[g])
                else $error("lock mode held after request fell");
        end
    endgenerate

endmodule : oct_top
